// file: pkg/lite_timer_pkg.sv
package lite_timer_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] CSR_IDX = 8'h0b;
  localparam logic [7:0] CAP_IDX = 8'h0c;

  // Control/status field positions.
  localparam int CSR_CAP_IRQ_EN = 7;
  localparam int CSR_CAP_FLAG = 6;
  localparam int CSR_DOUBLE = 5;
  localparam int CSR_PER_IRQ_EN = 4;
  localparam int CSR_PER_FLAG = 3;
  localparam int CSR_RST_STATUS = 2;
  localparam int CSR_WDG_EN = 1;
  localparam int CSR_REFRESH = 0;

  // Counter and prescaler.
  localparam logic [4:0] PRESCALE_LAST = 5'h1f;
  localparam logic [7:0] COUNT_TOP = 8'hf9;
  localparam logic [7:0] COUNT_RESET = 8'h00;

  // Cycles after a halt exit before the watchdog runs again.
  localparam logic [8:0] HOLDOFF_CYCLES = 9'h100;

  // Values after reset.
  localparam logic [7:0] CAPTURE_RESET = 8'h00;
  localparam logic CAP_FLAG_RESET = 1'b0;

endpackage : lite_timer_pkg

// file: rtl/timebase_watchdog_capture_timer.sv
// Functional notes
// RL1: Hidden counter from zero, step per 32 clocks.
// RL2: Overflow when counter wraps F9h to 00h.
// RL3: Period 8000 clocks, or 16000 when doubled.
// RL4: Period sets flag; interrupt when flag and enable.
// RL5: Status read clears period flag; writes ignored.
// RL6: Enabled watchdog resets at unrefreshed period end.
// RL7: Refresh bit cleared each period; set avoids reset.
// RL8: Period counted from reset; late enable resets.
// RL9: Enable then write status bit forces reset.
// RL10: Watchdog reset sets status; low-voltage reset clears.
// RL11: Status left set resets on next enable.
// RL12: Hardware watchdog option keeps watchdog always on.
// RL13: Halt stops counter and suppresses watchdog resets.
// RL14: Watchdog resumes 256 clocks after halt exit.
// RL15: Pin edge captures counter, sets capture flag.
// RL16: Capture flag clears only on capture read.
// RL17: Set capture flag blocks further captures.
// RL18: Software reads capture after reset to clear.
// RL19: Other low-power modes leave timer running.
// RL20: Separate period and capture interrupt requests.
// RL21: Capture pin synchronised before edge detection.
`timescale 1ns/10ps
module timebase_watchdog_capture_timer
  import lite_timer_pkg::*;
(
  // Clock and resets.
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic lowVoltageResetN,
  // Avalon-MM register slave.
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Device options and power state.
  input wire logic hwWatchdog,
  input wire logic haltMode,
  // External capture pin.
  input wire logic captureInputPin,
  // Requests to the rest of the device.
  output logic watchdogReset,
  output logic periodIrq,
  output logic captureIrq
);

  typedef struct packed {
    logic [4:0] prescale;
    logic [7:0] count;
    logic tbPhase;
    logic wdgPhase;
    logic capIrqEn;
    logic capFlag;
    logic doubleSel;
    logic perIrqEn;
    logic perFlag;
    logic resetStatus;
    logic readSeen;
    logic wdgEn;
    logic refresh;
    logic pending;
    logic enPrev;
    logic haltPrev;
    logic [8:0] holdoff;
    logic [7:0] capture;
    logic [2:0] pinSync;
    logic pinLevel;
    logic waitReq;
    logic [7:0] rdata;
    logic wdgRst;
    logic perIrq;
    logic capIrq;
  } state_t;

  localparam state_t STATE_RESET = '{
    prescale: 5'h00,
    count: COUNT_RESET,
    tbPhase: 1'b0,
    wdgPhase: 1'b0,
    capIrqEn: 1'b0,
    capFlag: CAP_FLAG_RESET,
    doubleSel: 1'b0,
    perIrqEn: 1'b0,
    perFlag: 1'b0,
    resetStatus: 1'b0,
    readSeen: 1'b0,
    wdgEn: 1'b0,
    refresh: 1'b0,
    pending: 1'b0,
    enPrev: 1'b0,
    haltPrev: 1'b0,
    holdoff: 9'h000,
    capture: CAPTURE_RESET,
    pinSync: 3'h0,
    pinLevel: 1'b0,
    waitReq: 1'b1,
    rdata: 8'h00,
    wdgRst: 1'b0,
    perIrq: 1'b0,
    capIrq: 1'b0
  };

  state_t state_r;
  state_t state_nxt;

  // Register decode: word aligned, index times four.
  function automatic logic hits(input logic [7:0] addr,
                                input logic [7:0] idx);
    hits = (addr[1:0] == 2'h0) && (addr[7:2] == idx[5:0]) &&
           (idx[7:6] == 2'h0);
  endfunction : hits

  logic overflow;
  logic periodEvt;
  logic periodEnd;
  logic wdgActive;
  logic wdgRun;
  logic accept;
  logic wrCsr;
  logic rdCsr;
  logic rdCap;
  logic pinEdge;
  logic fireReset;

  // Next-state logic for the whole block.
  always_comb
  begin
    state_nxt = state_r;
    accept = (read || write) && !state_r.waitReq;
    wrCsr = accept && write && byteenable[0] && hits(address, CSR_IDX);
    rdCsr = accept && read && hits(address, CSR_IDX);
    rdCap = accept && read && hits(address, CAP_IDX);

    // Counter freezes in halt because the oscillator is stopped.
    overflow = 1'b0;
    if (!haltMode) // RL13 RL19
    begin
      state_nxt.prescale = state_r.prescale + 5'h01; // RL1
      if (state_r.prescale == PRESCALE_LAST)
      begin
        overflow = (state_r.count == COUNT_TOP); // RL2
        state_nxt.count = overflow ? COUNT_RESET :
                          state_r.count + 8'h01; // RL1
      end
    end

    // Timebase: every overflow, or every second one when doubled.
    periodEvt = overflow && (!state_r.doubleSel || state_r.tbPhase); // RL3
    if (overflow)
      state_nxt.tbPhase = state_r.doubleSel ? !state_r.tbPhase : 1'b0;

    // Watchdog period is two overflows, counted from reset.
    wdgActive = hwWatchdog || state_r.wdgEn; // RL12
    wdgRun = !haltMode && (state_r.holdoff == 9'h000); // RL13 RL14
    periodEnd = overflow && wdgRun && state_r.wdgPhase; // RL8
    if (overflow && wdgRun)
      state_nxt.wdgPhase = !state_r.wdgPhase;
    state_nxt.haltPrev = haltMode;
    if (state_r.haltPrev && !haltMode)
      state_nxt.holdoff = HOLDOFF_CYCLES; // RL14
    else if (state_r.holdoff != 9'h000)
      state_nxt.holdoff = state_r.holdoff - 9'h001;

    // Bus writes to control bits; flag positions are ignored.
    if (wrCsr)
    begin
      state_nxt.capIrqEn = writedata[CSR_CAP_IRQ_EN];
      state_nxt.doubleSel = writedata[CSR_DOUBLE];
      state_nxt.perIrqEn = writedata[CSR_PER_IRQ_EN];
      state_nxt.wdgEn = writedata[CSR_WDG_EN];
      if (writedata[CSR_REFRESH])
      begin
        state_nxt.refresh = 1'b1; // RL7
        state_nxt.pending = 1'b0; // RL8
      end
      // Status clears by software only after a status read.
      if (!writedata[CSR_RST_STATUS] && state_r.readSeen)
        state_nxt.resetStatus = 1'b0; // RL10
    end

    // Watchdog period end: the refresh bit absorbs one expiry.
    fireReset = 1'b0;
    if (periodEnd)
    begin
      state_nxt.refresh = 1'b0; // RL7
      if (!state_r.refresh)
      begin
        if (wdgActive)
          fireReset = 1'b1; // RL6
        else
          state_nxt.pending = 1'b1; // RL8
      end
    end
    if (wdgActive && wdgRun && state_r.pending && !state_nxt.refresh)
      fireReset = 1'b1; // RL8
    if (wrCsr && writedata[CSR_RST_STATUS] && wdgActive)
      fireReset = 1'b1; // RL9
    if (wdgActive && !state_r.enPrev && state_r.resetStatus)
      fireReset = 1'b1; // RL11
    if (haltMode)
      fireReset = 1'b0; // RL13
    // A pending expiry is spent by the reset it causes, so it fires once.
    if (fireReset)
      state_nxt.pending = 1'b0; // RL8
    state_nxt.enPrev = wdgActive;
    state_nxt.wdgRst = fireReset;
    if (state_r.wdgRst)
      state_nxt.resetStatus = 1'b1; // RL10
    if (!lowVoltageResetN)
      state_nxt.resetStatus = 1'b0; // RL10
    if (rdCsr)
      state_nxt.readSeen = 1'b1;
    if (state_r.wdgRst || !lowVoltageResetN)
      state_nxt.readSeen = 1'b0;

    // Period flag: cleared only if the read returned it set.
    if (rdCsr && state_r.rdata[CSR_PER_FLAG])
      state_nxt.perFlag = 1'b0; // RL5
    if (periodEvt)
      state_nxt.perFlag = 1'b1; // RL4

    // Pin filter: a level counts once stages two and three agree.
    state_nxt.pinSync = {state_r.pinSync[1:0], captureInputPin}; // RL21
    if (state_r.pinSync[1] == state_r.pinSync[2])
      state_nxt.pinLevel = state_r.pinSync[2]; // RL21
    pinEdge = (state_r.pinSync[1] == state_r.pinSync[2]) &&
              (state_r.pinSync[2] != state_r.pinLevel); // RL15

    // Capture: a set flag locks the captured value.
    if (rdCap)
      state_nxt.capFlag = 1'b0; // RL16 RL18
    if (pinEdge && !state_r.capFlag) // RL17
    begin
      state_nxt.capture = state_r.count; // RL15
      state_nxt.capFlag = 1'b1; // RL15
    end

    // Separate registered requests for each event source.
    state_nxt.perIrq = state_nxt.perFlag && state_nxt.perIrqEn; // RL4 RL20
    state_nxt.capIrq = state_nxt.capFlag && state_nxt.capIrqEn; // RL15 RL20

    // One wait cycle per access; read data is held for the accept edge.
    state_nxt.waitReq = !((read || write) && state_r.waitReq);
    if ((read || write) && state_r.waitReq)
    begin
      state_nxt.rdata = 8'h00;
      if (read && hits(address, CSR_IDX))
        state_nxt.rdata = {state_r.capIrqEn, state_r.capFlag,
                           state_r.doubleSel, state_r.perIrqEn,
                           state_r.perFlag, state_r.resetStatus,
                           state_r.wdgEn, state_r.refresh};
      else if (read && hits(address, CAP_IDX))
        state_nxt.rdata = state_r.capture;
    end
  end

  // State register; the reset status survives a plain system reset.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state_r <= STATE_RESET;
      state_r.resetStatus <= state_nxt.resetStatus; // RL10
    end
    else
      state_r <= state_nxt;
  end

  // Outputs straight from the state register.
  assign readdata = {24'h000000, state_r.rdata};
  assign waitrequest = state_r.waitReq;
  assign watchdogReset = state_r.wdgRst;
  assign periodIrq = state_r.perIrq;
  assign captureIrq = state_r.capIrq;

endmodule : timebase_watchdog_capture_timer

// file: dv/lite_timer_checker.sv
`timescale 1ns/10ps
module lite_timer_checker
  import lite_timer_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register bus.
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Options and requests.
  input wire logic hwWatchdog,
  input wire logic haltMode,
  input wire logic watchdogReset,
  input wire logic periodIrq,
  input wire logic captureIrq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic csrWr;
  logic clrHit;
  logic enSeen_r;
  // Accepted accesses that are allowed to drop an interrupt request.
  assign csrWr = write && !waitrequest && address == 8'h2c;
  assign clrHit = !waitrequest && ((read && address == 8'h30)
    || ((read || write) && address == 8'h2c));
  // Software enable as last written, so a forced reset can be predicted.
  always_ff @(posedge clk_sys)
    if (!rst_n)
      enSeen_r <= 1'b0;
    else if (csrWr)
      enSeen_r <= writedata[CSR_WDG_EN];
  AST_BUS_ANSWER: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus request not answered in the next cycle");
  AST_BUS_ONE: assert property (!waitrequest |=> waitrequest)
    else $error("bus answer held longer than one cycle");
  AST_UNMAPPED: assert property (read && !waitrequest && address != 8'h2c
    && address != 8'h30 |-> readdata == 32'h0)
    else $error("unmapped read returned data");
  AST_HALT_QUIET: assert property (haltMode && $past(haltMode) |-> !watchdogReset)
    else $error("watchdog reset during halt");
  AST_HALT_EXIT: assert property ($fell(haltMode) |=> !watchdogReset [*8])
    else $error("watchdog reset right after halt exit");
  AST_PER_CLEAR: assert property ($fell(periodIrq) |-> $past(clrHit) || $past(clrHit, 2))
    else $error("period request dropped without a status access");
  AST_CAP_CLEAR: assert property ($fell(captureIrq) |-> $past(clrHit) || $past(clrHit, 2))
    else $error("capture request dropped without a read");
  AST_FORCE: assert property (csrWr && writedata[CSR_RST_STATUS] && !haltMode
    && (enSeen_r || hwWatchdog) |-> ##[1:2] watchdogReset)
    else $error("forced watchdog reset missing");
endmodule : lite_timer_checker
bind timebase_watchdog_capture_timer lite_timer_checker lite_timer_checker_inst (
  .clk_sys(clk_sys), .rst_n(rst_n), .address(address), .read(read),
  .write(write), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .hwWatchdog(hwWatchdog), .haltMode(haltMode),
  .watchdogReset(watchdogReset), .periodIrq(periodIrq),
  .captureIrq(captureIrq));

// file: dv/tb_timebase_watchdog_capture_timer.sv
`timescale 1ns/10ps
module tb_timebase_watchdog_capture_timer;
  localparam logic [7:0] CSR = 8'h2c;
  localparam logic [7:0] CAP = 8'h30;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic lowVoltageResetN = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic haltMode = 1'b0;
  logic captureInputPin = 1'b0;
  logic [31:0] readdata;
  logic waitrequest, watchdogReset, periodIrq, captureIrq, hit;
  logic [7:0] rd;
  int mismatches = 0;
  int nCompared = 0;
  int rel = 0;
  int cyc = 0;
  int resets = 0;
  int t0;
  timebase_watchdog_capture_timer timebase_watchdog_capture_timer_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .lowVoltageResetN(lowVoltageResetN),
    .address(address), .read(read), .write(write), .byteenable(4'hf),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .hwWatchdog(1'b0), .haltMode(haltMode), .captureInputPin(captureInputPin),
    .watchdogReset(watchdogReset), .periodIrq(periodIrq),
    .captureIrq(captureIrq));
  // Free-running clock at 25 MHz.
  initial
    forever #20 clk_sys = ~clk_sys;
  // Cycles since reset release, reset requests seen, and the hang limit.
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    rel <= rst_n ? rel + 1 : 0;
    if (watchdogReset === 1'b1)
      resets <= resets + 1;
    if (cyc == 90000)
    begin
      mismatches++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("Compared %0d, mismatches %0d", nCompared, mismatches);
    if (mismatches == 0 && nCompared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    nCompared++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One bus cycle; the extra edge keeps back-to-back calls from
  // assigning read or write twice in one time step.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    address <= a;
    writedata <= {24'h0, d};
    read <= !wr;
    write <= wr;
    @(posedge clk_sys);
    while (waitrequest !== 1'b0)
      @(posedge clk_sys);
    rd = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk_sys);
  endtask : bus
  task automatic waitfor(input logic cap, input int lim);
    hit = 1'b0;
    repeat (lim)
      if (!hit)
      begin
        @(posedge clk_sys);
        hit = ((cap ? captureIrq : periodIrq) === 1'b1);
      end
  endtask : waitfor
  task automatic rstp(input logic lv);
    rst_n <= 1'b0;
    lowVoltageResetN <= !lv;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    lowVoltageResetN <= 1'b1;
    @(posedge clk_sys);
  endtask : rstp
  initial
  begin
    void'($urandom(32'hbfb7));
    @(posedge clk_sys);
    rstp(1'b1);
    bus(1'b1, CSR, 8'h13);
    bus(1'b0, CAP, 8'h00);
    chk("capture", 8'h00, rd);
    bus(1'b1, CAP, 8'h5a);
    bus(1'b0, 8'h34, 8'h00);
    chk("unmapped", 8'h00, rd);
    repeat (4)
    begin
      t0 = $urandom & 32'h88;
      bus(1'b1, CSR, t0[7:0] | 8'h13);
      bus(1'b0, CSR, 8'h00);
      chk("csr", t0[7:0] & 8'h80 | 8'h13, rd);
    end
    // Edge placed mid-count so the expected capture is unambiguous.
    bus(1'b1, CSR, 8'h93);
    while (rel % 32 != 12)
      @(posedge clk_sys);
    t0 = (rel / 32) % 250;
    captureInputPin <= ~captureInputPin;
    waitfor(1'b1, 10);
    chk("capture irq", 8'h01, {7'h0, hit});
    captureInputPin <= ~captureInputPin;
    repeat (10) @(posedge clk_sys);
    bus(1'b0, CAP, 8'h00);
    chk("capture", t0[7:0], rd);
    chk("capture irq", 8'h00, {7'h0, captureIrq});
    waitfor(1'b0, 9000);
    t0 = rel;
    bus(1'b0, CSR, 8'h00);
    chk("period flag", 8'h08, rd & 8'h08);
    waitfor(1'b0, 9000);
    chk("period", 8'h01, {7'h0, rel - t0 == 8000});
    while (resets == 0 && rel < 33000)
      @(posedge clk_sys);
    chk("expiry", 8'h01, {7'h0, rel > 31990 && rel < 32012});
    rstp(1'b0);
    bus(1'b0, CSR, 8'h00);
    chk("csr", 8'h04, rd);
    bus(1'b1, CSR, 8'h30);
    bus(1'b0, CSR, 8'h00);
    chk("csr", 8'h30, rd);
    waitfor(1'b0, 17000);
    t0 = rel;
    bus(1'b0, CSR, 8'h00);
    waitfor(1'b0, 17000);
    chk("period", 8'h01, {7'h0, rel - t0 == 16000});
    t0 = resets;
    bus(1'b1, CSR, 8'h02);
    repeat (4) @(posedge clk_sys);
    chk("resets", t0[7:0] + 8'h01, resets[7:0]);
    rstp(1'b0);
    bus(1'b0, CSR, 8'h00);
    bus(1'b1, CSR, 8'h00);
    t0 = resets;
    bus(1'b1, CSR, 8'h03);
    bus(1'b1, CSR, 8'h07);
    repeat (4) @(posedge clk_sys);
    chk("resets", t0[7:0] + 8'h01, resets[7:0]);
    rstp(1'b0);
    t0 = resets;
    bus(1'b1, CSR, 8'h02);
    repeat (4) @(posedge clk_sys);
    chk("resets", t0[7:0] + 8'h01, resets[7:0]);
    rstp(1'b1);
    bus(1'b0, CSR, 8'h00);
    chk("csr", 8'h00, rd);
    haltMode <= 1'b1;
    repeat (20) @(posedge clk_sys);
    haltMode <= 1'b0;
    repeat (20) @(posedge clk_sys);
    complete_run();
  end
endmodule : tb_timebase_watchdog_capture_timer
